// [nemc_pkg.sv]
// package for the narrow external memory control pin layer
// assumes a single clock domain (mclk) and no register bus
package nemc_pkg;
  // chip-space select field in the word address
  localparam int SPACE_FIELD_LO = 26;
  localparam int SPACE_FIELD_HI = 31;
  localparam int NUM_SPACES = 4;
  localparam int FIFO_SPACE = 3;
  // clock source strap codes
  localparam logic [1:0] CLK_SRC_PIN = 2'h0;
  localparam logic [1:0] CLK_SRC_DIV4 = 2'h1;
  localparam logic [1:0] CLK_SRC_DIV6 = 2'h2;
  localparam logic [1:0] CLK_SRC_RSVD = 2'h3;
  localparam logic [1:0] CLK_SRC_RESET = 2'h0;
  // divider of second output clock
  localparam logic [1:0] OUT_DIV_1 = 2'h0;
  localparam logic [1:0] OUT_DIV_2 = 2'h1;
  localparam logic [1:0] OUT_DIV_4 = 2'h2;
  // memory types of a space
  localparam logic [1:0] MEM_ASYNC = 2'h0;
  localparam logic [1:0] MEM_SDRAM = 2'h1;
  localparam logic [1:0] MEM_SYNC = 2'h2;
  // access timing, in interface clock ticks
  localparam logic [3:0] STROBE_TICKS = 4'h2;
  localparam logic [7:0] SDRAM_CAS_GAP = 8'h2;
  // reset values of strobes (active low, idle high)
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic [3:0] SELECT_IDLE = 4'hf;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_STROBE = 6'b000100,
    ST_WAIT = 6'b001000,
    ST_HOLD = 6'b010000,
    ST_HOST = 6'b100000
  } nemc_state_type;
endpackage

// [nemc_fifo.sv]
// small request fifo, flip-flop storage
// assumes one clock; both sides use valid/ready
`timescale 1ns/1ns
module nemc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("nemc_fifo: depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;
  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule // nemc_fifo

// [nemc_ctrl.sv]
// control-pin layer of a 16-bit external memory port
// assumes inputs synchronous to mclk; pins active low except clocks, async ready,
// pins_oe, access_done and the hold/bus handshake, which are active high in this model
`timescale 1ns/1ns
module nemc_ctrl #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic iface_clock_in,
  input wire logic [1:0] clock_select_straps,
  input wire logic [1:0] out_div_sel,
  input wire logic [7:0] space_mem_type,
  input wire logic [3:0] read_enable_select,
  input wire logic wide_mode,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [31:0] req_addr,
  input wire logic [1:0] req_size,
  input wire logic req_write,
  input wire logic req_periph,
  input wire logic host_hold_request,
  input wire logic async_ready_in,
  output logic [1:0] iface_clock_source_sel,
  output logic iface_clock_out_full,
  output logic iface_clock_out_div,
  output logic space_select_3,
  output logic space_select_2,
  output logic space_select_1,
  output logic space_select_0,
  output logic byte_lane_enable_1,
  output logic byte_lane_enable_0,
  output logic periph_direct_xfer,
  output logic host_hold_ack,
  output logic own_bus_request,
  output logic shared_strobe_a,
  output logic shared_strobe_b,
  output logic shared_strobe_w,
  output logic fifo_space_out_enable,
  output logic pins_oe,
  output logic access_done
);
  initial begin
    if (FIFO_DEPTH != 4)
      $error("nemc_ctrl: request buffer depth must be 4");
  end

  // request word: periph, write, size, addr
  localparam int RW = 36;
  logic [RW-1:0] fifo_out;
  logic fifo_valid;
  logic fifo_pop;
  logic [31:0] cur_addr;
  logic [1:0] cur_size;
  logic cur_write;
  logic cur_periph;

  nemc_fifo #(.WIDTH(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_periph, req_write, req_size, req_addr}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );
  assign {cur_periph, cur_write, cur_size, cur_addr} = fifo_out;

  // space index from the high word-address field; values beyond 3 fold down
  function automatic logic [1:0] space_of(input logic [31:0] a);
    logic [5:0] f;
    f = a[nemc_pkg::SPACE_FIELD_HI:nemc_pkg::SPACE_FIELD_LO];
    space_of = f[1:0];
  endfunction

  // byte enables, active low; 8-bit memory uses only lane 0
  function automatic logic [1:0] lanes_of(input logic a0, input logic [1:0] sz,
                                          input logic wide);
    if (!wide) begin
      lanes_of = 2'h2;
    end else if (sz != 2'h0) begin
      lanes_of = 2'h0;
    end else begin
      lanes_of = a0 ? 2'h1 : 2'h2;
    end
  endfunction

  // clock source strap capture, clocked at reset release
  logic strap_taken_q;
  logic [1:0] clk_src_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      strap_taken_q <= 1'b0;
      clk_src_q <= nemc_pkg::CLK_SRC_RESET;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      // reserved code falls back to the pin
      if (clock_select_straps == nemc_pkg::CLK_SRC_RSVD) begin
        clk_src_q <= nemc_pkg::CLK_SRC_PIN;
      end else begin
        clk_src_q <= clock_select_straps;
      end
    end
  end
  assign iface_clock_source_sel = clk_src_q;

  // internal divide-by-4 and divide-by-6 of mclk as cpu clock stand-in
  logic [2:0] cpu_div_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cpu_div_q <= 3'h0;
    end else if (cpu_div_q == 3'h5) begin
      cpu_div_q <= 3'h0;
    end else begin
      cpu_div_q <= cpu_div_q + 3'h1;
    end
  end
  logic [1:0] cpu_div4_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cpu_div4_q <= 2'h0;
    end else begin
      cpu_div4_q <= cpu_div4_q + 2'h1;
    end
  end
  logic src_level;
  always_comb begin
    case (clk_src_q)
      nemc_pkg::CLK_SRC_DIV4: src_level = cpu_div4_q[1];
      nemc_pkg::CLK_SRC_DIV6: src_level = cpu_div_q >= 3'h3;
      default: src_level = iface_clock_in;
    endcase
  end
  // rising edge of the chosen source is the interface tick; pin is
  // sampled, so it must be well below half of mclk
  logic src_q;
  logic tick;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      src_q <= 1'b0;
    end else begin
      src_q <= src_level;
    end
  end
  assign tick = src_level && !src_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      iface_clock_out_full <= 1'b0;
    end else begin
      iface_clock_out_full <= src_level;
    end
  end
  logic [1:0] div_cnt_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_q <= 2'h0;
    end else if (tick) begin
      div_cnt_q <= div_cnt_q + 2'h1;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      iface_clock_out_div <= 1'b0;
    end else begin
      case (out_div_sel)
        nemc_pkg::OUT_DIV_2: iface_clock_out_div <= div_cnt_q[0];
        nemc_pkg::OUT_DIV_4: iface_clock_out_div <= div_cnt_q[1];
        default: iface_clock_out_div <= src_level;
      endcase
    end
  end

  // access sequencer, advancing on interface ticks
  nemc_pkg::nemc_state_type state_q;
  logic [3:0] cnt_q;
  logic [1:0] space;
  logic [1:0] mtype;
  logic rd_sel;
  assign space = space_of(cur_addr);
  assign mtype = space_mem_type[space*2 +: 2];
  assign rd_sel = read_enable_select[space];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= nemc_pkg::ST_IDLE;
      cnt_q <= 4'h0;
    end else if (tick) begin
      case (state_q)
        nemc_pkg::ST_IDLE: begin
          if (host_hold_request) begin
            state_q <= nemc_pkg::ST_HOST;
          end else if (fifo_valid) begin
            state_q <= nemc_pkg::ST_SETUP;
          end
        end
        nemc_pkg::ST_SETUP: begin
          state_q <= nemc_pkg::ST_STROBE;
          cnt_q <= nemc_pkg::STROBE_TICKS;
        end
        nemc_pkg::ST_STROBE: begin
          if (cnt_q > 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (mtype == nemc_pkg::MEM_ASYNC && !async_ready_in) begin
            state_q <= nemc_pkg::ST_WAIT;
          end else begin
            state_q <= nemc_pkg::ST_HOLD;
          end
        end
        nemc_pkg::ST_WAIT: begin
          // strobe stays low until ready is seen high
          if (async_ready_in) begin
            state_q <= nemc_pkg::ST_HOLD;
          end
        end
        nemc_pkg::ST_HOLD: state_q <= nemc_pkg::ST_IDLE;
        nemc_pkg::ST_HOST: begin
          if (!host_hold_request) begin
            state_q <= nemc_pkg::ST_IDLE;
          end
        end
        default: state_q <= nemc_pkg::ST_IDLE;
      endcase
    end
  end
  assign fifo_pop = tick && state_q == nemc_pkg::ST_HOLD;
  assign access_done = fifo_pop;

  logic in_access;
  logic strobing;
  assign in_access = state_q == nemc_pkg::ST_SETUP || state_q == nemc_pkg::ST_STROBE ||
                     state_q == nemc_pkg::ST_WAIT || state_q == nemc_pkg::ST_HOLD;
  assign strobing = state_q == nemc_pkg::ST_STROBE || state_q == nemc_pkg::ST_WAIT;

  // pin registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {space_select_3, space_select_2, space_select_1, space_select_0} <=
        nemc_pkg::SELECT_IDLE;
    end else if (in_access) begin
      // one-hot low: only one space at a time
      {space_select_3, space_select_2, space_select_1, space_select_0} <=
        ~(4'h1 << space);
    end else begin
      {space_select_3, space_select_2, space_select_1, space_select_0} <=
        nemc_pkg::SELECT_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {byte_lane_enable_1, byte_lane_enable_0} <= 2'h3;
    end else if (in_access) begin
      // same pins serve as write enables and SDRAM mask
      {byte_lane_enable_1, byte_lane_enable_0} <=
        lanes_of(cur_addr[0], cur_size, wide_mode);
    end else begin
      {byte_lane_enable_1, byte_lane_enable_0} <= 2'h3;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      periph_direct_xfer <= nemc_pkg::STROBE_IDLE;
    end else begin
      periph_direct_xfer <= !(in_access && cur_periph);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      host_hold_ack <= 1'b0;
    end else begin
      host_hold_ack <= state_q == nemc_pkg::ST_HOST;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      own_bus_request <= 1'b0;
    end else begin
      // asked while held off so the host can yield
      own_bus_request <= fifo_valid;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pins_oe <= 1'b1;
    end else begin
      pins_oe <= state_q != nemc_pkg::ST_HOST;
    end
  end

  // shared strobes; sdram here is a single-command model, no refresh
  logic a_d;
  logic b_d;
  logic w_d;
  always_comb begin
    a_d = nemc_pkg::STROBE_IDLE;
    b_d = nemc_pkg::STROBE_IDLE;
    w_d = nemc_pkg::STROBE_IDLE;
    case (mtype)
      nemc_pkg::MEM_ASYNC: begin
        a_d = !(strobing && !cur_write);
        b_d = !(in_access && !cur_write);
        w_d = !(strobing && cur_write);
      end
      nemc_pkg::MEM_SDRAM: begin
        a_d = !(state_q == nemc_pkg::ST_STROBE);
        b_d = !(state_q == nemc_pkg::ST_SETUP);
        w_d = !(state_q == nemc_pkg::ST_STROBE && cur_write);
      end
      nemc_pkg::MEM_SYNC: begin
        if (rd_sel) begin
          a_d = !(strobing && !cur_write);
        end else begin
          a_d = !(state_q == nemc_pkg::ST_SETUP);
        end
        b_d = !(strobing && !cur_write);
        w_d = !(strobing && cur_write);
      end
      default: begin
        a_d = nemc_pkg::STROBE_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      shared_strobe_a <= nemc_pkg::STROBE_IDLE;
      shared_strobe_b <= nemc_pkg::STROBE_IDLE;
      shared_strobe_w <= nemc_pkg::STROBE_IDLE;
    end else begin
      shared_strobe_a <= a_d;
      shared_strobe_b <= b_d;
      shared_strobe_w <= w_d;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fifo_space_out_enable <= nemc_pkg::STROBE_IDLE;
    end else begin
      fifo_space_out_enable <= !(mtype == nemc_pkg::MEM_SYNC && strobing && !cur_write &&
                                 space == 2'(nemc_pkg::FIFO_SPACE));
    end
  end
endmodule // nemc_ctrl

// [nemc_ctrl_assertions.sv]
// checker on the port relations of nemc_ctrl
// assumes one mclk domain; bound onto every nemc_ctrl instance
`timescale 1ns/1ns
module nemc_ctrl_chk (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wide_mode,
  input wire logic host_hold_request,
  input wire logic [1:0] iface_clock_source_sel,
  input wire logic space_select_3,
  input wire logic space_select_2,
  input wire logic space_select_1,
  input wire logic space_select_0,
  input wire logic byte_lane_enable_1,
  input wire logic periph_direct_xfer,
  input wire logic host_hold_ack,
  input wire logic fifo_space_out_enable
);
  logic [3:0] sel_n;
  assign sel_n = {space_select_3, space_select_2, space_select_1, space_select_0};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_grant;
    $rose(host_hold_ack);
  endsequence
  sequence s_drop;
    $fell(host_hold_request);
  endsequence
  chk_one_space: assert property ($onehot0(~sel_n))
    else $error("two space selects low together");
  chk_grant_cause: assert property (s_grant |-> $past(host_hold_request))
    else $error("hold ack rose without a request");
  chk_host_idle: assert property (host_hold_ack |-> sel_n == 4'hf)
    else $error("space select low while host holds the bus");
  // bounded: a host left waiting for release would stall the whole bus
  chk_ack_release: assert property (s_drop |-> ##[0:8] !host_hold_ack)
    else $error("hold ack kept after request dropped");
  chk_fifo_oe_space: assert property (!fifo_space_out_enable |-> !space_select_3)
    else $error("fifo output enable outside the fourth space");
  chk_src_legal: assert property (iface_clock_source_sel != nemc_pkg::CLK_SRC_RSVD)
    else $error("reserved clock source latched");
  chk_src_held: assert property ($past(rstn, 2) |-> $stable(iface_clock_source_sel))
    else $error("clock source changed after reset");
  chk_narrow_lane: assert property (!wide_mode && !$past(wide_mode) |-> byte_lane_enable_1)
    else $error("upper lane used in 8-bit mode");
  chk_periph_space: assert property (!periph_direct_xfer |-> sel_n != 4'hf)
    else $error("peripheral transfer without a space select");
endmodule // nemc_ctrl_chk
bind nemc_ctrl nemc_ctrl_chk i_nemc_ctrl_chk (.mclk, .rstn, .wide_mode, .host_hold_request,
  .iface_clock_source_sel, .space_select_3, .space_select_2, .space_select_1, .space_select_0,
  .byte_lane_enable_1, .periph_direct_xfer, .host_hold_ack, .fifo_space_out_enable);

// [nemc_far_model.sv]
// far-side model: async memory ready and a bus host
// assumes strobes active low, ready and hold request active high
`timescale 1ns/1ns
module nemc_far_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic shared_strobe_a,
  input wire logic shared_strobe_w,
  input wire logic [3:0] wait_cycles,
  input wire logic host_want,
  output logic async_ready_in,
  output logic host_hold_request
);
  logic [3:0] cnt_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      cnt_q <= 4'h0;
    else if (shared_strobe_a && shared_strobe_w)
      cnt_q <= 4'h0;
    else if (cnt_q != 4'hf)
      cnt_q <= cnt_q + 4'h1;
  end
  // ready low until the strobe stood wait_cycles; pull-up level between accesses
  assign async_ready_in = (shared_strobe_a && shared_strobe_w) || (cnt_q >= wait_cycles);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      host_hold_request <= 1'b0;
    else
      host_hold_request <= host_want;
  end
endmodule // nemc_far_model

// [nemc_ctrl_test.sv]
// bench for nemc_ctrl with the far-side model
// assumes mclk 100 MHz and an interface clock fed at mclk/4
`timescale 1ns/1ns
module nemc_ctrl_test;
  logic mclk, rstn, iface_clock_in, wide_mode, req_valid, req_write, req_periph, host_want;
  logic [1:0] clock_select_straps, out_div_sel, req_size, iface_clock_source_sel, div_q;
  logic [7:0] space_mem_type;
  logic [3:0] read_enable_select, wait_cycles, sel_seen;
  logic [31:0] req_addr;
  logic req_ready, host_hold_request, async_ready_in, iface_clock_out_full;
  logic iface_clock_out_div, space_select_3, space_select_2, space_select_1, space_select_0;
  logic byte_lane_enable_1, byte_lane_enable_0, periph_direct_xfer, host_hold_ack;
  logic own_bus_request, shared_strobe_a, shared_strobe_b, shared_strobe_w;
  logic fifo_space_out_enable, pins_oe, access_done, pd_seen, oe3_seen, b_seen, w_seen;
  logic [1:0] lane_seen;
  int err_total, compares, done_cnt, a_cnt;
  nemc_ctrl #(.FIFO_DEPTH(4)) i_nemc_ctrl (.*);
  nemc_far_model i_nemc_far_model (.*);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    div_q <= div_q + 2'h1;
    iface_clock_in <= div_q[1];
  end
  // sticky pin history, sampled mid-cycle where the registered pins are settled
  always @(negedge mclk) begin
    sel_seen |= ~{space_select_3, space_select_2, space_select_1, space_select_0};
    lane_seen |= ~{byte_lane_enable_1, byte_lane_enable_0};
    pd_seen |= !periph_direct_xfer;
    oe3_seen |= !fifo_space_out_enable;
    b_seen |= !shared_strobe_b;
    w_seen |= !shared_strobe_w;
    a_cnt += (shared_strobe_a === 1'b0);
    done_cnt += (access_done === 1'b1);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic bit near(input int n, input int e);
    return n >= e - 1 && n <= e + 1;
  endfunction
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic clear;
    @(posedge mclk);
    sel_seen = 4'h0;
    lane_seen = 2'h0;
    {pd_seen, oe3_seen, b_seen, w_seen} = 4'h0;
    a_cnt = 0;
    done_cnt = 0;
  endtask
  task automatic push(input logic [31:0] a, input logic [1:0] sz, input logic wr,
      input logic pd, output logic ok);
    ok = 1'b0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_addr <= a;
    req_size <= sz;
    req_write <= wr;
    req_periph <= pd;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(negedge mclk);
      ok = (req_ready === 1'b1);
    end
    @(posedge mclk);
    req_valid <= 1'b0;
  endtask
  task automatic wait_done(input int k);
    for (int n = 0; n < 400 && done_cnt < k; n++) @(negedge mclk);
    check(done_cnt >= k, 1);
    repeat (3) @(negedge mclk);
  endtask
  task automatic acc(input logic [31:0] a, input logic [1:0] sz, input logic wr, input logic pd);
    logic ok;
    clear();
    push(a, sz, wr, pd, ok);
    wait_done(1);
  endtask
  task automatic count_rise(input bit div, output int n);
    logic prev, cur;
    n = 0;
    prev = 1'b1;
    repeat (240) begin
      @(negedge mclk);
      cur = div ? iface_clock_out_div : iface_clock_out_full;
      n += (cur === 1'b1 && prev === 1'b0);
      prev = cur;
    end
  endtask
  task automatic t_straps;
    int n;
    for (int c = 0; c < 4; c++) begin
      @(posedge mclk);
      rstn <= 1'b0;
      clock_select_straps <= 2'(c);
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(negedge mclk);
      check(iface_clock_source_sel, (c == 3) ? 0 : c);
      count_rise(1'b0, n);
      check(near(n, (c == 2) ? 40 : 60), 1);
    end
    $display("test straps done");
  endtask
  task automatic t_div;
    int n;
    for (int d = 0; d < 4; d++) begin
      @(posedge mclk);
      out_div_sel <= 2'(d);
      repeat (16) @(posedge mclk);
      count_rise(1'b1, n);
      check(near(n, (d == 2) ? 15 : (d == 1) ? 30 : 60), 1);
    end
    $display("test divider done");
  endtask
  task automatic t_spaces;
    for (int s = 0; s < 4; s++) begin
      acc(32'(s) << 26, 2'h1, 1'b0, 1'b0);
      check(sel_seen, 4'h1 << s);
      check(oe3_seen, s == 3);
      check(pd_seen, 0);
    end
    acc(32'h1400_0000, 2'h1, 1'b0, 1'b1);
    check(sel_seen, 4'h2);
    check(pd_seen, 1);
    $display("test spaces done");
  endtask
  task automatic t_lanes;
    logic [5:0] tbl [4];
    tbl = '{6'b101111, 6'b100001, 6'b110010, 6'b010001};
    foreach (tbl[i]) begin
      @(posedge mclk);
      wide_mode <= tbl[i][5];
      acc({31'h0, tbl[i][4]}, tbl[i][3:2], 1'b1, 1'b0);
      check(lane_seen, tbl[i][1:0]);
      check(w_seen, 1);
    end
    @(posedge mclk);
    wide_mode <= 1'b1;
    $display("test lanes done");
  endtask
  task automatic stb(input logic [31:0] a, input logic wr, input logic [2:0] m,
      input logic [2:0] e);
    acc(a, 2'h1, wr, 1'b0);
    check({a_cnt > 0, b_seen, w_seen} & m, e);
  endtask
  task automatic t_strobes;
    stb(32'h0000_0000, 1'b0, 3'h7, 3'h6);
    stb(32'h0000_0000, 1'b1, 3'h5, 3'h1);
    stb(32'h0400_0000, 1'b0, 3'h7, 3'h6);
    stb(32'h0800_0000, 1'b0, 3'h5, 3'h4);
    // address strobe spans the setup tick only: four mclk at mclk/4
    check(a_cnt, 4);
    @(posedge mclk);
    read_enable_select <= 4'h4;
    stb(32'h0800_0000, 1'b0, 3'h5, 3'h4);
    check(a_cnt, 4 * nemc_pkg::STROBE_TICKS);
    stb(32'h0800_0000, 1'b1, 3'h5, 3'h1);
    $display("test strobes done");
  endtask
  task automatic t_ready;
    int fast;
    @(posedge mclk);
    wait_cycles <= 4'h0;
    acc(32'h0, 2'h1, 1'b0, 1'b0);
    fast = a_cnt;
    @(posedge mclk);
    wait_cycles <= 4'hc;
    acc(32'h0, 2'h1, 1'b0, 1'b0);
    check(a_cnt > fast, 1);
    check(a_cnt >= 12, 1);
    @(posedge mclk);
    wait_cycles <= 4'h0;
    $display("test ready done");
  endtask
  task automatic t_hold;
    logic ok;
    int taken;
    taken = 0;
    @(posedge mclk);
    host_want <= 1'b1;
    for (int n = 0; n < 50 && host_hold_ack !== 1'b1; n++) @(negedge mclk);
    check(host_hold_ack, 1);
    check(pins_oe, 0);
    clear();
    repeat (5) begin
      push(32'h0, 2'h1, 1'b1, 1'b0, ok);
      taken += ok;
    end
    check(taken, 4);
    check(own_bus_request, 1);
    check(sel_seen, 0);
    @(posedge mclk);
    host_want <= 1'b0;
    wait_done(4);
    check(host_hold_ack, 0);
    check(own_bus_request, 0);
    check(req_ready, 1);
    $display("test hold done");
  endtask
  initial begin
    {rstn, iface_clock_in, req_valid, req_write, req_periph, host_want} = 6'h0;
    {clock_select_straps, out_div_sel, req_size, div_q} = 8'h0;
    {wide_mode, space_mem_type, read_enable_select, wait_cycles} = 17'h1_a400;
    req_addr = 32'h0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    t_straps();
    t_div();
    t_spaces();
    t_lanes();
    t_strobes();
    t_ready();
    t_hold();
    final_report();
  end
  initial begin
    #200000;
    err_total++;
    final_report();
  end
endmodule // nemc_ctrl_test
